// >>> shared/dsr_pkg.sv
// shared constants for the device settings register block
package dsr_pkg;
  // bus and register map
  localparam int          DATA_W         = 32;
  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  SETTINGS_ADDR  = 4'h0;   // device_settings, read/write
  localparam logic [3:0]  STATUS_ADDR    = 4'h4;   // filtered fault flags, read only
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // device_settings fields
  localparam int          SET_W          = 12;
  localparam int          REV_COMP_BIT   = 11;
  localparam int          BT_HIGH_BIT    = 10;
  localparam int          BT_LOW_BIT     = 9;
  localparam int          DCC_TEN_BIT    = 2;
  localparam int          DCC_NINE_BIT   = 1;
  localparam int          DCC_LOW8_BIT   = 0;
  localparam logic [11:0] SETTINGS_RESET = 12'h007;

  // channels
  localparam int          NUM_CH         = 10;
  localparam int          FILT_FIRST     = 6;      // channel 7, zero based
  localparam int          NUM_FILT       = 4;      // channels 7 to 10

  // timing, 20 MHz clock
  localparam int          CLK_MHZ        = 20;
  localparam int          STD_FILTER_US  = 150;
  localparam int          BLIND_SHORT_US = 2500;
  localparam int          BLIND_LONG_US  = 5000;
  localparam int          STD_FILTER_CYC  = STD_FILTER_US * CLK_MHZ;
  localparam int          BLIND_SHORT_CYC = BLIND_SHORT_US * CLK_MHZ;
  localparam int          BLIND_LONG_CYC  = BLIND_LONG_US * CLK_MHZ;
  localparam int          CNT_W          = 17;
endpackage : dsr_pkg

// >>> rtl/dsr_fault_filter.sv
// fault qualification counter for one channel
`timescale 1ns/100ps
module dsr_fault_filter
  import dsr_pkg::*;
#(
  parameter int CW = CNT_W
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // control
  input  wire logic          enable,      // detection allowed
  input  wire logic [CW-1:0] limit,       // cycles the fault must persist
  // fault in and out
  input  wire logic          fault_in,    // already synchronised
  output logic               fault_out    // qualified fault
);
  logic [CW-1:0] count;  // cycles the fault has persisted

  // count while the raw fault stands; any drop restarts the wait
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable || !fault_in) begin
      count <= '0;
    end else if (count < limit) begin
      count <= count + 1'b1;
    end
  end

  // flag once the full time has passed; a shorter limit mid-wait acts at once
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable || !fault_in) begin
      fault_out <= 1'b0;
    end else if (count >= limit) begin
      fault_out <= 1'b1;
    end
  end
endmodule : dsr_fault_filter

// >>> rtl/dsr_settings.sv
// device settings register with axi4-lite slave and channel diagnosis controls
//
// Function
// - reverse bit enables comparison, all channels
// - blind bits pick 150us, 2.5ms or 5ms
// - bit0 ch1-8, bit1 ch9, bit2 ch10
// - zero: no current, off-state detection off
// - one: current and both detections on; default one
`timescale 1ns/100ps
module dsr_settings
  import dsr_pkg::*;
#(
  parameter int STD_CYC   = STD_FILTER_CYC,   // standard filter length
  parameter int SHORT_CYC = BLIND_SHORT_CYC,  // short off-state blind time
  parameter int LONG_CYC  = BLIND_LONG_CYC    // long off-state blind time
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  // axi4-lite write data
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // axi4-lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  // axi4-lite read data
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // channel state and raw off-state faults from the output stages
  input  wire logic [NUM_CH-1:0] ch_on,
  input  wire logic [NUM_CH-1:0] offstate_fault_raw,
  // controls to the output stages
  output logic                   reverse_current_comp_enable,
  output logic [NUM_CH-1:0]      diag_current_en,
  output logic [NUM_CH-1:0]      offstate_diag_en,
  output logic [NUM_CH-1:0]      onstate_diag_en,
  // qualified faults, channels 7 to 10
  output logic [NUM_FILT-1:0]    offstate_fault
);
  // register contents and timing limits
  logic [SET_W-1:0]    device_settings;  // the settings word
  logic [CNT_W-1:0]    lim_std;          // standard filter in cycles
  logic [CNT_W-1:0]    lim_short;        // 2.5 ms blind in cycles
  logic [CNT_W-1:0]    lim_long;         // 5 ms blind in cycles
  // write channel holding
  logic                aw_full;          // address captured
  logic                w_full;           // data captured
  logic [ADDR_W-1:0]   aw_q;             // captured address
  logic [DATA_W-1:0]   w_q;              // captured data
  logic [3:0]          ws_q;             // captured strobes
  logic                wr_commit;        // both halves present, slot free
  logic                wr_ok;            // commit is to a legal target
  // synchronisers for pins
  logic [NUM_CH-1:0]   on_s1, on_s2;     // channel state
  logic [NUM_CH-1:0]   flt_s1, flt_s2;   // raw faults
  // aliases of fields
  logic                dcc_low8;
  logic                dcc_nine;
  logic                dcc_ten;
  logic [1:0]          blind_sel;        // {high, low}

  assign lim_std   = CNT_W'(STD_CYC);
  assign lim_short = CNT_W'(SHORT_CYC);
  assign lim_long  = CNT_W'(LONG_CYC);

  assign dcc_low8  = device_settings[DCC_LOW8_BIT];
  assign dcc_nine  = device_settings[DCC_NINE_BIT];
  assign dcc_ten   = device_settings[DCC_TEN_BIT];
  assign blind_sel = {device_settings[BT_HIGH_BIT], device_settings[BT_LOW_BIT]};

  // ---------------- write path ----------------
  // each half held until the pair is complete; nothing new while a response waits
  assign awready   = !aw_full && !bvalid;
  assign wready    = !w_full && !bvalid;
  assign wr_commit = aw_full && w_full && !bvalid;
  // a settings write needs both low lanes so the word changes in one step
  assign wr_ok     = (aw_q == SETTINGS_ADDR) && (ws_q[1:0] == 2'h3);

  // capture write address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_q    <= '0;
    end else if (awvalid && awready) begin
      aw_full <= 1'b1;
      aw_q    <= awaddr;
    end else if (wr_commit) begin
      aw_full <= 1'b0;
    end
  end

  // capture write data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_q    <= '0;
      ws_q   <= '0;
    end else if (wvalid && wready) begin
      w_full <= 1'b1;
      w_q    <= wdata;
      ws_q   <= wstrb;
    end else if (wr_commit) begin
      w_full <= 1'b0;
    end
  end

  // settings word; reserved bits are stored as written so reads match
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      device_settings <= SETTINGS_RESET;
    end else if (wr_commit && wr_ok) begin
      device_settings <= w_q[SET_W-1:0];
    end
  end

  // write response; status offset is read only, so writes there fail too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_commit) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ---------------- read path ----------------
  assign arready = !rvalid;

  // read data is registered; unmapped offsets answer slverr with zero data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      case (araddr)
        SETTINGS_ADDR: begin
          rdata <= {{(DATA_W-SET_W){1'b0}}, device_settings};
          rresp <= RESP_OKAY;
        end
        STATUS_ADDR: begin
          rdata <= {{(DATA_W-NUM_FILT){1'b0}}, offstate_fault};
          rresp <= RESP_OKAY;
        end
        default: begin
          rdata <= '0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------- channel controls ----------------
  // outputs follow the register directly: effective the cycle after commit
  assign reverse_current_comp_enable = device_settings[REV_COMP_BIT];
  // channels 1-8 share one bit, 9 and 10 have their own
  assign diag_current_en  = {dcc_ten, dcc_nine, {8{dcc_low8}}};
  // off-state detection only while diagnosis current flows
  assign offstate_diag_en = diag_current_en;
  // overcurrent and overtemperature never switched off by these bits
  assign onstate_diag_en  = {NUM_CH{1'b1}};

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_s1  <= '0;
      on_s2  <= '0;
      flt_s1 <= '0;
      flt_s2 <= '0;
    end else begin
      on_s1  <= ch_on;
      on_s2  <= on_s1;
      flt_s1 <= offstate_fault_raw;
      flt_s2 <= flt_s1;
    end
  end

  // ---------------- filters for channels 7 to 10 ----------------
  logic [CNT_W-1:0] ch_limit [NUM_FILT];  // selected wait per channel

  genvar g;
  generate
    for (g = 0; g < NUM_FILT; g++) begin : g_filt
      // blind time only stretches the off state; on state keeps standard filter
      always_comb begin
        if (!blind_sel[0] || on_s2[FILT_FIRST+g]) begin
          ch_limit[g] = lim_std;
        end else if (blind_sel[1]) begin
          ch_limit[g] = lim_long;
        end else begin
          ch_limit[g] = lim_short;
        end
      end

      dsr_fault_filter #(
        .CW(CNT_W)
      ) u_filt (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .enable   (offstate_diag_en[FILT_FIRST+g]),
        .limit    (ch_limit[g]),
        .fault_in (flt_s2[FILT_FIRST+g]),
        .fault_out(offstate_fault[g])
      );
    end
  endgenerate

  // ---------------- assertions ----------------
  property p_rev_follows;
    @(posedge aclk) disable iff (!aresetn)
      wr_commit && wr_ok |=> reverse_current_comp_enable == $past(w_q[REV_COMP_BIT]);
  endproperty
  a_rev_follows: assert property (p_rev_follows)
    else $error("reverse comparison enable does not follow write");

  property p_group_split;
    @(posedge aclk) disable iff (!aresetn)
      wr_commit && wr_ok |=> diag_current_en[7:0] == {8{$past(w_q[0])}}
        && diag_current_en[8] == $past(w_q[1]) && diag_current_en[9] == $past(w_q[2]);
  endproperty
  a_group_split: assert property (p_group_split)
    else $error("diagnosis current group mapping wrong");

  property p_off_no_fault;
    @(posedge aclk) disable iff (!aresetn)
      !offstate_diag_en[NUM_CH-1] |=> !offstate_fault[NUM_FILT-1];
  endproperty
  a_off_no_fault: assert property (p_off_no_fault)
    else $error("fault reported with off-state diagnosis disabled");

  property p_onstate_kept;
    @(posedge aclk) disable iff (!aresetn)
      $fell(diag_current_en[0]) |-> onstate_diag_en == {NUM_CH{1'b1}};
  endproperty
  a_onstate_kept: assert property (p_onstate_kept)
    else $error("on-state diagnosis dropped");

  property p_on_enables;
    @(posedge aclk) disable iff (!aresetn)
      dcc_ten |-> diag_current_en[9] && offstate_diag_en[9];
  endproperty
  a_on_enables: assert property (p_on_enables)
    else $error("diagnosis not enabled with control bit set");

  property p_blind_sel;
    @(posedge aclk) disable iff (!aresetn)
      blind_sel == 2'h3 && !on_s2[FILT_FIRST] |-> ch_limit[0] == lim_long;
  endproperty
  a_blind_sel: assert property (p_blind_sel)
    else $error("long blind time not selected");

  property p_std_sel;
    @(posedge aclk) disable iff (!aresetn)
      blind_sel[0] == 1'b0 |-> ch_limit[3] == lim_std;
  endproperty
  a_std_sel: assert property (p_std_sel)
    else $error("standard filter not selected");

  property p_readback;
    @(posedge aclk) disable iff (!aresetn)
      arvalid && arready && araddr == SETTINGS_ADDR
        |=> rvalid && rdata[SET_W-1:0] == $past(device_settings);
  endproperty
  a_readback: assert property (p_readback)
    else $error("settings read back wrong");

  property p_wr_resp;
    @(posedge aclk) disable iff (!aresetn)
      awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response late");

  // the word only moves on an accepted write, never on a refused one
  property p_settings_hold;
    @(posedge aclk) disable iff (!aresetn)
      !(wr_commit && wr_ok) |=> $stable(device_settings);
  endproperty
  a_settings_hold: assert property (p_settings_hold)
    else $error("settings changed without an accepted write");

  c_write_ok: cover property (@(posedge aclk) disable iff (!aresetn) wr_commit && wr_ok);
  c_write_bad: cover property (@(posedge aclk) disable iff (!aresetn) wr_commit && !wr_ok);
  c_fault: cover property (@(posedge aclk) disable iff (!aresetn) $rose(offstate_fault[0]));
endmodule : dsr_settings

// >>> verification/tb_device_settings_register.sv
// self-checking testbench for the device settings register block
`timescale 1ns/100ps
module tb_device_settings_register;
  import dsr_pkg::*;
  // shortened filter lengths keep the run brief
  localparam int STD_T   = 5;
  localparam int SHORT_T = 10;
  localparam int LONG_T  = 20;
  logic                aclk, aresetn;
  logic [ADDR_W-1:0]   awaddr, araddr;
  logic                awvalid, wvalid, bready, arvalid, rready;
  logic                awready, wready, bvalid, arready, rvalid;
  logic [DATA_W-1:0]   wdata, rdata, rd;
  logic [3:0]          wstrb;
  logic [1:0]          bresp, rresp, rsp;
  logic [NUM_CH-1:0]   ch_on, fault_raw, cur_en, off_en, on_en;
  logic                rev_en;
  logic [NUM_FILT-1:0] filt_fault;
  int                  miscompares, checked, seed, model;

  dsr_settings #(.STD_CYC(STD_T), .SHORT_CYC(SHORT_T), .LONG_CYC(LONG_T)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ch_on(ch_on), .offstate_fault_raw(fault_raw),
    .reverse_current_comp_enable(rev_en), .diag_current_en(cur_en),
    .offstate_diag_en(off_en), .onstate_diag_en(on_en), .offstate_fault(filt_fault));

  // 20 MHz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // verdict and end of run, shared by every timeout
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // one comparison, four-state exact
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // a wait that ran out counts as a mismatch and ends the run
  task automatic tmo(input string what);
    miscompares++;
    $display("MISMATCH at %0t: %s timed out", $time, what);
    finish_test();
  endtask : tmo

  // axi4-lite write: address and data offered together, each released when taken
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int n;
    bit aw_ok, w_ok;
    @(posedge aclk);
    aw_ok = 0;
    w_ok = 0;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
      if (++n > 50) tmo("write request");
    end
    n = 0;
    do begin
      @(posedge aclk);
      if (++n > 50) tmo("write response");
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  // axi4-lite read, rready held until rvalid is seen
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (++n > 50) tmo("read address");
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      if (++n > 50) tmo("read data");
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  // control outputs against the model of the register
  task automatic check_out();
    logic [9:0] grp;
    grp = {model[2], model[1], {8{model[0]}}};
    check(32'(rev_en), 32'(model[11]), "reverse comparison enable");
    check(32'(cur_en), 32'(grp), "diagnosis current");
    check(32'(off_en), 32'(grp), "off-state detection");
    check(32'(on_en), 32'h3ff, "on-state detection");
  endtask : check_out

  // write a legal value, then check outputs and read back
  task automatic wr_check(input logic [31:0] v);
    axi_write(SETTINGS_ADDR, v, 4'hf, rsp);
    check(32'(rsp), 32'(RESP_OKAY), "write response");
    model = int'(v & 32'hfff);
    check_out();
    axi_read(SETTINGS_ADDR, rd, rsp);
    check(rd, 32'(model), "read back");
    check(32'(rsp), 32'(RESP_OKAY), "read response");
  endtask : wr_check

  // hold a raw fault on one channel and time its qualification
  task automatic filt(input int ch, input bit on, input int lim, input bit en);
    int n;
    @(posedge aclk);
    ch_on <= on ? (10'h1 << ch) : 10'h0;
    fault_raw <= 10'h1 << ch;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (filt_fault[ch-FILT_FIRST] !== 1'b1 && n < lim + 40);
    if (en) begin
      check(32'(n >= lim + 1 && n <= lim + 5), 32'h1, "filter length");
    end else begin
      check(32'(filt_fault), 32'h0, "detection while disabled");
    end
    // the status word shows the same qualified fault while the raw fault stands
    axi_read(STATUS_ADDR, rd, rsp);
    check(rd, en ? 32'h1 << (ch - FILT_FIRST) : 32'h0, "status read");
    fault_raw <= '0;
    ch_on <= '0;
    // two sync flops plus the clearing edge
    repeat (5) @(posedge aclk);
    check(32'(filt_fault), 32'h0, "fault cleared");
  endtask : filt

  // main sequence
  initial begin
    logic [11:0] bt_val [4];
    int          bt_lim [4];
    bt_val = '{12'h007, 12'h407, 12'h207, 12'h607};
    bt_lim = '{STD_T, STD_T, SHORT_T, LONG_T};
    seed = 32'hdc46;
    miscompares = 0;
    checked = 0;
    aresetn = 1'b0;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    {wdata, wstrb, ch_on, fault_raw} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values
    model = 32'h007;
    axi_read(SETTINGS_ADDR, rd, rsp);
    check(rd, 32'h007, "reset value");
    check_out();
    $display("test reset done");
    // every diagnosis current pattern, random upper fields, spare bits zero
    for (int i = 0; i < 8; i++) wr_check(($random(seed) & 32'he00) | i);
    $display("test field mapping done");
    // refused writes leave the register whole
    axi_write(SETTINGS_ADDR, 32'h0a00, 4'h1, rsp);
    check(32'(rsp), 32'(RESP_SLVERR), "partial strobe");
    axi_write(4'h8, 32'h0a00, 4'hf, rsp);
    check(32'(rsp), 32'(RESP_SLVERR), "unmapped write");
    axi_write(STATUS_ADDR, 32'h0a00, 4'hf, rsp);
    check(32'(rsp), 32'(RESP_SLVERR), "read-only write");
    axi_read(SETTINGS_ADDR, rd, rsp);
    check(rd, 32'(model), "unchanged after refusals");
    check_out();
    axi_read(4'h8, rd, rsp);
    check(rd, 32'h0, "unmapped read data");
    check(32'(rsp), 32'(RESP_SLVERR), "unmapped read");
    $display("test refusals done");
    // each blind time pattern on its own filtered channel
    for (int i = 0; i < 4; i++) begin
      wr_check(32'(bt_val[i]));
      filt(FILT_FIRST + i, 1'b0, bt_lim[i], 1'b1);
    end
    // an on channel keeps the standard filter
    wr_check(32'h207);
    filt(9, 1'b1, STD_T, 1'b1);
    // channel ten current off: its detection stays quiet
    wr_check(32'h003);
    filt(9, 1'b0, STD_T, 1'b0);
    $display("test filters done");
    finish_test();
  end
endmodule : tb_device_settings_register
